/* File: include/rcw_pkg.sv */
// constants and types for the reset cause and watchdog block
package rcw_pkg;
    localparam int CLK_MHZ  = 200;
    localparam int POWERON_DELAY_US  = 10;
    localparam int MONITOR_START_DELAY_US = 100;
    localparam int PWRT1_MS = 4;
    localparam int PWRT2_MS = 16;
    localparam int PWRT3_MS = 64;
    localparam int POR_CYC   = POWERON_DELAY_US * CLK_MHZ;
    localparam int CLOCK_FAIL_MONITOR_CYC  = MONITOR_START_DELAY_US * CLK_MHZ;
    localparam int PWRT1_CYC = PWRT1_MS * 1000 * CLK_MHZ;
    localparam int PWRT2_CYC = PWRT2_MS * 1000 * CLK_MHZ;
    localparam int PWRT3_CYC = PWRT3_MS * 1000 * CLK_MHZ;
    localparam int OST_CYC   = 1024;
    localparam int WDT_BITS  = 8;

    localparam logic [3:0] ADDR_RESET_CAUSE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CFG  = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;

    // reset_cause_control bit positions
    localparam int B_POR    = 0;
    localparam int B_BOR    = 1;
    localparam int B_IDLE   = 2;
    localparam int B_SLEEP  = 3;
    localparam int B_WATCHDOG_TIMEOUT_FLAG   = 4;
    localparam int B_WATCHDOG_SOFT_ENABLE = 5;
    localparam int B_SWR    = 6;
    localparam int B_EXTERNAL_RESET_FLAG   = 7;
    localparam int B_ILLOP  = 8;
    localparam int B_TRAP   = 9;
    localparam logic [15:0] RESET_CAUSE_CONTROL_RST   = 16'h0003;
    localparam logic [15:0] RESET_CAUSE_CONTROL_WMASK = 16'h03ff;

    // synchroniser lanes: below[2:0], pin_n, clk_run, lock, rc
    localparam logic [6:0] SYNC_RST = 7'h08;

    typedef struct packed {
        logic       pll;
        logic       osc;
        logic       clock_fail_monitor;
        logic       wdt_en;
        logic [1:0] powerup_timer;
        logic [1:0] bor_lvl;
        logic       bor_en;
    } rcw_cfg_t;
    localparam logic [8:0] CFG_RST = 9'h021;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN  = 2'b10
    } rcw_state_t;

    typedef enum logic [1:0] {
        VEC_RESET = 2'b00,
        VEC_NEXT  = 2'b01,
        VEC_IRQ   = 2'b10
    } rcw_vec_t;
endpackage : rcw_pkg

/* File: hdl/rcw_top.sv */
// reset sequencer, reset cause register and watchdog
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module rcw_top
    import rcw_pkg::*;
#(
    parameter int CLOCK_FAIL_MONITOR_CYCLES  = CLOCK_FAIL_MONITOR_CYC,
    parameter int PWRT1_CYCLES = PWRT1_CYC,
    parameter int PWRT2_CYCLES = PWRT2_CYC,
    parameter int PWRT3_CYCLES = PWRT3_CYC,
    parameter int OST_CYCLES   = OST_CYC,
    parameter int WDT_W        = WDT_BITS
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [2:0]  i_supply_below,
    input  wire logic        i_ext_reset_pin_n,
    input  wire logic        i_sysclk_running,
    input  wire logic        i_pll_lock,
    input  wire logic        i_wdt_rc_clk,
    input  wire logic        i_sw_reset,
    input  wire logic        i_trap_lockup,
    input  wire logic        i_illegal_op,
    input  wire logic        i_wdt_clear,
    input  wire logic        i_sleep,
    input  wire logic        i_idle,
    input  wire logic        i_irq_wake,
    output logic             o_sys_reset,
    output logic             o_clk_hold,
    output logic             o_osc_reload,
    output logic             o_wake,
    output logic      [1:0]  o_vec_sel
);
    logic [6:0]       sync1_r;
    logic [6:0]       sync2_r;
    logic             pin_prev_r;
    logic             rc_prev_r;
    logic [15:0]      reset_cause_control_r;
    logic [15:0]      reset_cause_control_nxt;
    rcw_cfg_t         cfg_r;
    rcw_state_t       state_r;
    rcw_state_t       state_nxt;
    logic [23:0]      cnt_r;
    logic [23:0]      cnt_nxt;
    logic [23:0]      ost_r;
    logic [23:0]      ost_nxt;
    logic [WDT_W-1:0] wdt_r;
    logic             wait_r;
    logic [31:0]      rdata_r;
    logic             clk_hold_r;
    logic             sys_rst_r;
    logic             osc_reload_r;
    logic             wake_r;
    logic [1:0]       vec_r;
    logic [15:0]      set_m;
    logic [15:0]      clr_m;

    // a reserved level code falls back to the highest trip band
    function automatic logic bor_trip(input logic [1:0] lvl, input logic [2:0] below);
        return (lvl == 2'h3) ? below[2] : below[lvl];
    endfunction : bor_trip

    function automatic logic [23:0] hold_len(input rcw_cfg_t c);
        logic [23:0] extra;
        unique case (c.powerup_timer)
            2'h0:    extra = c.osc ? 24'(CLOCK_FAIL_MONITOR_CYCLES) : 24'h00_0000;
            2'h1:    extra = 24'(PWRT1_CYCLES);
            2'h2:    extra = 24'(PWRT2_CYCLES);
            default: extra = 24'(PWRT3_CYCLES);
        endcase
        return 24'(POR_CYC) + extra;
    endfunction : hold_len

    wire [2:0] below_s = sync2_r[6:4];
    wire       pin_n_s = sync2_r[3];
    wire       clk_run = sync2_r[2];
    wire       lock_s  = sync2_r[1];
    wire       rc_s    = sync2_r[0];

    wire acc     = (i_avs_read | i_avs_write) & ~wait_r;
    wire wr_reset_cause_control = acc & i_avs_write & (i_avs_address == ADDR_RESET_CAUSE_CONTROL);
    wire wr_cfg  = acc & i_avs_write & (i_avs_address == ADDR_CFG);
    wire run     = (state_r == ST_RUN);

    wire bor_lvl  = cfg_r.bor_en & bor_trip(cfg_r.bor_lvl, below_s);
    wire external_reset_pin_ev  = ~pin_n_s & pin_prev_r;
    wire sw_ev    = run & i_sw_reset;
    wire trap_ev  = run & i_trap_lockup;
    wire ill_ev   = run & i_illegal_op;
    wire wdt_en   = cfg_r.wdt_en | reset_cause_control_r[B_WATCHDOG_SOFT_ENABLE];
    wire rc_rise  = rc_s & ~rc_prev_r;
    wire wdt_ovf  = run & wdt_en & rc_rise & (&wdt_r);
    wire wdt_rst  = wdt_ovf & ~i_sleep;
    wire wdt_wake = wdt_ovf & i_sleep;
    wire irq_wake = run & i_sleep & i_irq_wake & ~wdt_ovf;
    wire rst_ev   = bor_lvl | external_reset_pin_ev | sw_ev | trap_ev | ill_ev | wdt_rst;
    wire rst_req  = rst_ev | ~pin_n_s;
    wire ost_done = ~cfg_r.osc | (ost_r == 24'h00_0000);
    wire lock_ok  = ~cfg_r.pll | lock_s;
    wire rel_ok   = ost_done & lock_ok & (cfg_r.clock_fail_monitor | clk_run);

    wire [15:0] reset_cause_control_base = wr_reset_cause_control ? (i_avs_writedata[15:0] & RESET_CAUSE_CONTROL_WMASK) : reset_cause_control_r;
    wire [31:0] stat_word = 32'({wdt_r, state_r, clk_hold_r, sys_rst_r});
    wire [31:0] rd_mux    = (i_avs_address == ADDR_RESET_CAUSE_CONTROL) ? {16'h0000, reset_cause_control_r} :
                            (i_avs_address == ADDR_CFG)  ? {23'h00_0000, cfg_r} :
                            (i_avs_address == ADDR_STAT) ? stat_word : 32'h0000_0000;

    // clears first, then sets, so a hardware set always beats a clear
    always_comb begin
        set_m = 16'h0000;
        clr_m = 16'h0000;
        if (bor_lvl) begin
            set_m[B_BOR] = 1'b1;
            clr_m[B_POR] = 1'b1;
        end
        if (external_reset_pin_ev) begin
            set_m[B_EXTERNAL_RESET_FLAG] = 1'b1;
            clr_m[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            if (i_sleep) begin
                set_m[B_SLEEP] = 1'b1;
                clr_m[B_IDLE]  = 1'b1;
            end else if (i_idle) begin
                set_m[B_IDLE]   = 1'b1;
                clr_m[B_SLEEP]  = 1'b1;
            end else begin
                clr_m[B_SWR]   = 1'b1;
                clr_m[B_IDLE]  = 1'b1;
                clr_m[B_SLEEP] = 1'b1;
            end
        end
        if (sw_ev) begin
            set_m[B_SWR] = 1'b1;
            clr_m[B_EXTERNAL_RESET_FLAG] = 1'b1;
            clr_m[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            clr_m[B_IDLE] = 1'b1;
            clr_m[B_SLEEP] = 1'b1;
        end
        if (wdt_rst) begin
            set_m[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
            clr_m[B_EXTERNAL_RESET_FLAG] = 1'b1;
            clr_m[B_SWR] = 1'b1;
            clr_m[B_IDLE] = 1'b1;
            clr_m[B_SLEEP] = 1'b1;
        end
        if (wdt_wake) begin
            set_m[B_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
            set_m[B_SLEEP] = 1'b1;
        end
        if (irq_wake) begin
            set_m[B_SLEEP] = 1'b1;
        end
        set_m[B_TRAP]  = trap_ev;
        set_m[B_ILLOP] = ill_ev;
        reset_cause_control_nxt = (reset_cause_control_base & ~clr_m) | set_m;
    end

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        ost_nxt   = (~run && ost_r != 24'h00_0000) ? ost_r - 24'h00_0001 : ost_r;
        if (rst_req) begin
            state_nxt = ST_HOLD;
            cnt_nxt   = hold_len(cfg_r);
            ost_nxt   = 24'(OST_CYCLES);
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    if (cnt_r == 24'h00_0000) begin
                        state_nxt = ST_WAIT;
                    end else begin
                        cnt_nxt = cnt_r - 24'h00_0001;
                    end
                end
                ST_WAIT: begin
                    if (rel_ok) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_nxt = ST_RUN;
                end
                default: begin
                    state_nxt = ST_HOLD;
                end
            endcase
        end
    end

    // second stage alone reads the first
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
        end else begin
            sync1_r <= {i_supply_below, i_ext_reset_pin_n, i_sysclk_running,
                         i_pll_lock, i_wdt_rc_clk};
            sync2_r <= sync1_r;
        end
    end

    // the watchdog counts rc clock edges sampled on i_clk, so a dead i_clk also stops it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wdt_r     <= '0;
            rc_prev_r <= 1'b0;
        end else begin
            rc_prev_r <= rc_s;
            if (!run || !wdt_en || i_wdt_clear || wdt_ovf) begin
                wdt_r <= '0;
            end else if (rc_rise) begin
                wdt_r <= wdt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_cause_control_r     <= RESET_CAUSE_CONTROL_RST;
            cfg_r      <= CFG_RST;
            pin_prev_r <= 1'b1;
        end else begin
            reset_cause_control_r     <= reset_cause_control_nxt;
            pin_prev_r <= pin_n_s;
            if (wr_cfg) begin
                cfg_r <= i_avs_writedata[8:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_HOLD;
            cnt_r   <= 24'(POR_CYC);
            ost_r   <= 24'(OST_CYCLES);
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            ost_r   <= ost_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sys_rst_r    <= 1'b1;
            clk_hold_r   <= 1'b0;
            osc_reload_r <= 1'b1;
            wake_r       <= 1'b0;
            vec_r        <= VEC_RESET;
        end else begin
            sys_rst_r    <= (state_nxt != ST_RUN);
            clk_hold_r   <= (state_nxt != ST_RUN) & ~(ost_done & lock_ok);
            osc_reload_r <= bor_lvl;
            wake_r       <= wdt_wake | irq_wake;
            if (rst_req) begin
                vec_r <= VEC_RESET;
            end else if (wdt_wake) begin
                vec_r <= VEC_NEXT;
            end else if (irq_wake) begin
                vec_r <= VEC_IRQ;
            end
        end
    end

    // one wait cycle per access; read data is captured while waitrequest is high
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= ~((i_avs_read | i_avs_write) & wait_r);
            if (i_avs_read && wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign o_avs_readdata    = rdata_r;
    assign o_avs_waitrequest = wait_r;
    assign o_sys_reset       = sys_rst_r;
    assign o_clk_hold        = clk_hold_r;
    assign o_osc_reload      = osc_reload_r;
    assign o_wake            = wake_r;
    assign o_vec_sel         = vec_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    wire solo = !(sw_ev | wdt_rst | wdt_wake | irq_wake | bor_lvl);

    sequence s_reset_taken;
        rst_req ##1 (sys_rst_r && state_r == ST_HOLD);
    endsequence

    sequence s_wake_flags;
        (reset_cause_control_r[B_WATCHDOG_TIMEOUT_FLAG] && reset_cause_control_r[B_SLEEP]) ##0 (wake_r && vec_r == VEC_NEXT);
    endsequence

    a_bor_flag_set: assert property (bor_lvl |=> reset_cause_control_r[B_BOR] && !reset_cause_control_r[B_POR])
        else $error("brownout flag not set");
    a_external_reset_pin_normal: assert property (external_reset_pin_ev && solo && !i_sleep && !i_idle |=>
        reset_cause_control_r[B_EXTERNAL_RESET_FLAG] && !reset_cause_control_r[B_SWR] && !reset_cause_control_r[B_SLEEP] && !reset_cause_control_r[B_IDLE])
        else $error("pin reset flags wrong");
    a_external_reset_pin_sleep: assert property (external_reset_pin_ev && solo && i_sleep |=>
        reset_cause_control_r[B_EXTERNAL_RESET_FLAG] && reset_cause_control_r[B_SLEEP] && !reset_cause_control_r[B_IDLE] && !reset_cause_control_r[B_WATCHDOG_TIMEOUT_FLAG])
        else $error("pin reset in sleep flags wrong");
    a_external_reset_pin_idle: assert property (external_reset_pin_ev && solo && !i_sleep && i_idle |=>
        reset_cause_control_r[B_EXTERNAL_RESET_FLAG] && reset_cause_control_r[B_IDLE] && !reset_cause_control_r[B_SLEEP])
        else $error("pin reset in idle flags wrong");
    a_sw_reset_flags: assert property (sw_ev && !external_reset_pin_ev && !wdt_ovf && !irq_wake |=>
        reset_cause_control_r[B_SWR] && !reset_cause_control_r[B_EXTERNAL_RESET_FLAG] && !reset_cause_control_r[B_WATCHDOG_TIMEOUT_FLAG] && !reset_cause_control_r[B_SLEEP])
        else $error("software reset flags wrong");
    a_wdt_wake_seq: assert property (wdt_wake && !rst_req |=> s_wake_flags)
        else $error("watchdog wake wrong");
    a_wdt_reset_hold: assert property (wdt_rst |-> s_reset_taken)
        else $error("watchdog overflow did not reset");
    a_irq_wake_vec: assert property (irq_wake && !rst_req |=>
        reset_cause_control_r[B_SLEEP] ##0 (wake_r && vec_r == VEC_IRQ))
        else $error("interrupt wake vector wrong");
    a_no_clock_hold: assert property (!cfg_r.clock_fail_monitor && !clk_run && !run |=> sys_rst_r)
        else $error("released without a system clock");
    a_hold_delay: assert property (rst_req |=> sys_rst_r [*8])
        else $error("reset released before the delay");
    a_soft_enable: assert property (!cfg_r.wdt_en && !reset_cause_control_r[B_WATCHDOG_SOFT_ENABLE] |=>
        (wdt_r == '0) || $past(wr_reset_cause_control))
        else $error("watchdog ran while disabled");
endmodule : rcw_top

/* File: verif/rcw_top_test.sv */
// self-checking bench for the reset cause and watchdog block
`timescale 1ns/100ps
module rcw_top_test
    import rcw_pkg::*;
();
    // short counts keep the run small; the hold-length expectations are derived from these and POR_CYC
    localparam int P1 = 100, P2 = 200, P3 = 300, FS = 50, LIMIT = 90000;
    localparam logic [15:0] PRE [6] = '{16'h03ff, 16'h0000, 16'h0000, 16'h03ff, 16'h03ff, 16'h03ff};
    localparam logic [15:0] EXP [6] = '{16'h0363, 16'h0200, 16'h0100, 16'h03a3, 16'h03eb, 16'h03e7};
    logic        i_clk, i_reset_n, i_avs_read, i_avs_write, i_sysclk_running, i_pll_lock;
    logic        i_ext_reset_pin_n, i_wdt_rc_clk, i_sw_reset, i_trap_lockup, i_illegal_op;
    logic        i_wdt_clear, i_sleep, i_idle, i_irq_wake;
    logic [3:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [2:0]  i_supply_below;
    logic        o_avs_waitrequest, o_sys_reset, o_clk_hold, o_osc_reload, o_wake;
    logic [1:0]  o_vec_sel;
    int          err_count, num_checks, cyc;

    rcw_top #(.CLOCK_FAIL_MONITOR_CYCLES(FS), .PWRT1_CYCLES(P1), .PWRT2_CYCLES(P2), .PWRT3_CYCLES(P3),
              .OST_CYCLES(16), .WDT_W(3)) i_rcw_top (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_supply_below(i_supply_below), .i_ext_reset_pin_n(i_ext_reset_pin_n),
        .i_sysclk_running(i_sysclk_running), .i_pll_lock(i_pll_lock),
        .i_wdt_rc_clk(i_wdt_rc_clk), .i_sw_reset(i_sw_reset), .i_trap_lockup(i_trap_lockup),
        .i_illegal_op(i_illegal_op), .i_wdt_clear(i_wdt_clear), .i_sleep(i_sleep),
        .i_idle(i_idle), .i_irq_wake(i_irq_wake), .o_sys_reset(o_sys_reset),
        .o_clk_hold(o_clk_hold), .o_osc_reload(o_osc_reload), .o_wake(o_wake),
        .o_vec_sel(o_vec_sel));

    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, num_checks);
        if (err_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // request held until the edge that samples waitrequest low, data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        @(posedge i_clk);
        i_avs_address   <= a;
        i_avs_writedata <= {16'h0000, d};
        i_avs_read      <= !wr;
        i_avs_write     <= wr;
        // no cycle count assumed here: only the bench timeout ends this wait
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(nm, q, {16'h0000, e});
    endtask : rd

    task automatic pulse_ev(input int k);
        @(posedge i_clk);
        case (k)
            0: i_sw_reset <= 1'b1;
            1: i_trap_lockup <= 1'b1;
            2: i_illegal_op <= 1'b1;
            3: i_irq_wake <= 1'b1;
            default: i_wdt_clear <= 1'b1;
        endcase
        @(posedge i_clk);
        {i_sw_reset, i_trap_lockup, i_illegal_op, i_irq_wake, i_wdt_clear} <= 5'h00;
    endtask : pulse_ev

    task automatic wait_rel(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_sys_reset !== 1'b0 && n < 5000);
        if (o_sys_reset !== 1'b0) chk("release", 32'(o_sys_reset), 0);
    endtask : wait_rel

    // rc levels held three cycles so the two-flop synchroniser sees every edge
    task automatic rc(input int n);
        repeat (n) begin
            @(posedge i_clk);
            i_wdt_rc_clk <= 1'b1;
            repeat (3) @(posedge i_clk);
            i_wdt_rc_clk <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask : rc

    task automatic t_powerup;
        int n;
        chk("rst_sys", 32'(o_sys_reset), 1);
        chk("rst_vec", 32'(o_vec_sel), 0);
        chk("rst_reload", 32'(o_osc_reload), 1);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (POR_CYC + 100) @(posedge i_clk);
        chk("frozen", 32'(o_sys_reset), 1);
        rd("reset_cause_control_rst", ADDR_RESET_CAUSE_CONTROL, 16'h0003);
        rd("cfg_rst", ADDR_CFG, 16'h0021);
        rd("unmapped", 4'hc, 16'h0000);
        i_sysclk_running <= 1'b1;
        wait_rel(n);
        chk("clk_start", 32'(n <= 10), 1);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h03ff);
        rd("reset_cause_control_set", ADDR_RESET_CAUSE_CONTROL, 16'h03ff);
    endtask : t_powerup

    task automatic t_cause(input int k);
        int n;
        wr(ADDR_RESET_CAUSE_CONTROL, PRE[k]);
        if (k < 3) pulse_ev(k);
        else begin
            i_sleep <= (k == 4);
            i_idle  <= (k == 5);
            @(posedge i_clk);
            i_ext_reset_pin_n <= 1'b0;
            repeat (6) @(posedge i_clk);
            i_ext_reset_pin_n <= 1'b1;
        end
        wait_rel(n);
        i_sleep <= 1'b0;
        i_idle  <= 1'b0;
        chk("cause_hold", 32'(n >= POR_CYC - 8), 1);
        rd("cause_flags", ADDR_RESET_CAUSE_CONTROL, EXP[k]);
    endtask : t_cause

    task automatic t_hold(input logic [15:0] cfg, input logic run, input int lk, input int hold);
        int n;
        wr(ADDR_CFG, cfg);
        i_sysclk_running <= run;
        i_pll_lock       <= (lk == 0);
        pulse_ev(0);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
            if (n == 4) chk("ost_hold", 32'(o_clk_hold), 32'(cfg[7] | cfg[8]));
            if (n == 40) chk("ost_done", 32'(o_clk_hold), 32'(cfg[8] && lk != 0));
            if (n == lk) begin
                chk("clk_hold", 32'(o_clk_hold), 1);
                i_pll_lock <= 1'b1;
            end
        end while (o_sys_reset !== 1'b0 && n < 5000);
        chk("hold_len", 32'(n >= hold && n <= hold + 8), 1);
        i_sysclk_running <= 1'b1;
    endtask : t_hold

    task automatic t_brownout(input int lvl);
        int n;
        wr(ADDR_CFG, 16'h0021 | 16'(lvl << 1));
        pulse_ev(0);
        wait_rel(n);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h03fd);
        i_sleep        <= (lvl == 2);
        i_supply_below <= 3'(7 << (lvl + 1));
        repeat (12) @(posedge i_clk);
        chk("bor_above", 32'(o_sys_reset), 0);
        chk("reload_idle", 32'(o_osc_reload), 0);
        i_supply_below <= 3'(7 << lvl);
        repeat (6) @(posedge i_clk);
        chk("bor_trip", 32'(o_sys_reset), 1);
        chk("bor_reload", 32'(o_osc_reload), 1);
        i_supply_below <= 3'h0;
        i_sleep        <= 1'b0;
        wait_rel(n);
        rd("bor_flags", ADDR_RESET_CAUSE_CONTROL, 16'h03fe);
    endtask : t_brownout

    task automatic t_watchdog;
        int n;
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h0000);
        rc(7);
        pulse_ev(4);
        rc(7);
        chk("wdt_early", 32'(o_sys_reset), 0);
        rc(1);
        chk("wdt_ovf", 32'(o_sys_reset), 1);
        wait_rel(n);
        rd("wdt_flags", ADDR_RESET_CAUSE_CONTROL, 16'h0010);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h0000);
        i_sleep <= 1'b1;
        rc(7);
        @(posedge i_clk);
        i_wdt_rc_clk <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_wake !== 1'b1 && n < 10);
        chk("wdt_wake", {o_wake, o_sys_reset, o_vec_sel}, {1'b1, 1'b0, VEC_NEXT});
        i_wdt_rc_clk <= 1'b0;
        rd("wake_flags", ADDR_RESET_CAUSE_CONTROL, 16'h0018);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h0000);
        pulse_ev(3);
        @(posedge i_clk);
        chk("irq_wake", {o_wake, o_vec_sel}, {1'b1, VEC_IRQ});
        @(posedge i_clk);
        chk("wake_pulse", 32'(o_wake), 0);
        i_sleep <= 1'b0;
        rd("irq_flags", ADDR_RESET_CAUSE_CONTROL, 16'h0008);
    endtask : t_watchdog

    task automatic t_soft_enable;
        int n;
        wr(ADDR_CFG, 16'h0001);
        pulse_ev(0);
        wait_rel(n);
        chk("vec_reset", 32'(o_vec_sel), 0);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h0000);
        rc(9);
        chk("wdt_off", 32'(o_sys_reset), 0);
        wr(ADDR_RESET_CAUSE_CONTROL, 16'h0020);
        rc(8);
        chk("wdt_soft_on", 32'(o_sys_reset), 1);
        wait_rel(n);
    endtask : t_soft_enable

    initial begin
        {i_reset_n, i_avs_read, i_avs_write, i_sysclk_running, i_pll_lock} = 5'h00;
        {i_wdt_rc_clk, i_sw_reset, i_trap_lockup, i_illegal_op, i_wdt_clear} = 5'h00;
        {i_sleep, i_idle, i_irq_wake} = 3'h0;
        i_ext_reset_pin_n = 1'b1;
        i_avs_address     = 4'h0;
        i_avs_writedata   = 32'h0000_0000;
        i_supply_below    = 3'h0;
        err_count         = 0;
        num_checks        = 0;
        cyc               = 0;
        repeat (4) @(posedge i_clk);
        t_powerup();
        i_pll_lock <= 1'b1;
        for (int k = 0; k < 6; k++) t_cause(k);
        t_hold(16'h0029, 1'b1, 0, POR_CYC + P1);
        t_hold(16'h0031, 1'b1, 0, POR_CYC + P2);
        t_hold(16'h0039, 1'b1, 0, POR_CYC + P3);
        t_hold(16'h00a1, 1'b1, 0, POR_CYC + FS);
        t_hold(16'h01a1, 1'b1, POR_CYC + 400, POR_CYC + 400);
        t_hold(16'h0061, 1'b0, 0, POR_CYC);
        t_hold(16'h0021, 1'b1, 0, POR_CYC);
        for (int l = 0; l < 3; l++) t_brownout(l);
        t_watchdog();
        t_soft_enable();
        stop_test();
    end
endmodule : rcw_top_test
